/* verilog/pvc_top.sv */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "pvc_consts.svh"

module pvc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ref_in,
   input  wire logic        vco_in,
   output logic             pump_output_pin_up,
   output logic             pump_output_pin_dn,
   output logic      [2:0]  pump_level,
   output logic             tune_voltage_pin_mid,
   output logic             swing_select_lo,
   output logic             swing_select_hi,
   output logic      [4:0]  cal_range_word,
   output logic             cal_done_n,
   output logic             lock_det
);

   pvc_pkg::pvc_top_s s;
   pvc_pkg::pvc_top_s next_s;
   logic              fb_pulse;
   logic              vco_edge;
   logic              ref_edge;
   logic              start_rise;
   logic              up_rise;
   logic              dn_rise;
   logic              fast;
   logic [2:0]        sel;
   logic              wr_en;

   function automatic logic [2:0] pvc_decode(input logic [11:0] addr);
      logic [2:0] r;
      unique case (addr)
         `PVC_ADDR_DIVN:   r = `PVC_SEL_DIVN;
         `PVC_ADDR_REFDIV: r = `PVC_SEL_REFDIV;
         `PVC_ADDR_CAL:    r = `PVC_SEL_CAL;
         `PVC_ADDR_CTRL:   r = `PVC_SEL_CTRL;
         `PVC_ADDR_STATUS: r = `PVC_SEL_STATUS;
         default:          r = `PVC_SEL_NONE;
      endcase
      return r;
   endfunction

   assign vco_edge = vco_in & ~s.vco_prev;

   pvc_fbdiv u_fbdiv (
      .pclk     (pclk),
      .presetn  (presetn),
      .vco_edge (vco_edge),
      .restart  (s.fb_restart),
      .cfg      (s.cfg),
      .fb_pulse (fb_pulse)
   );

   always_comb begin
      next_s = s;
      next_s.ref_prev = ref_in;
      next_s.vco_prev = vco_in;
      next_s.start_prev = s.cal_start;
      next_s.ref_pulse = 1'b0;
      next_s.fb_restart = 1'b0;
      ref_edge = ref_in & ~s.ref_prev;
      start_rise = s.cal_start & ~s.start_prev;
      fast = 1'b0;

      // register bus: one wait-free access phase
      sel = pvc_decode(paddr);
      wr_en = psel & penable & s.pready & pwrite & ~s.pslverr;
      next_s.pready = psel & ~penable;
      next_s.pslverr = psel & ~penable &
                       ((sel == `PVC_SEL_NONE) ||
                        (pwrite && sel == `PVC_SEL_STATUS));
      next_s.prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         unique case (sel)
            `PVC_SEL_DIVN: begin
               next_s.prdata[`PVC_DIVN_A_LSB +: 6] = s.cfg.a;
               next_s.prdata[`PVC_DIVN_B_LSB +: 9] = s.cfg.b;
            end
            `PVC_SEL_REFDIV: next_s.prdata[8:0] = s.r;
            `PVC_SEL_CAL: begin
               next_s.prdata[`PVC_CAL_START_BIT] = s.cal_start;
               next_s.prdata[`PVC_CAL_RST_BIT] = s.cal_rst;
            end
            `PVC_SEL_CTRL: begin
               next_s.prdata[`PVC_CTRL_CP_LSB +: 3] = s.cp_sel;
               next_s.prdata[`PVC_CTRL_SWLO_BIT] = s.swing[0];
               next_s.prdata[`PVC_CTRL_SWHI_BIT] = s.swing[1];
               next_s.prdata[`PVC_CTRL_PD_BIT] = s.pd;
            end
            `PVC_SEL_STATUS: begin
               // range word and status for the host
               next_s.prdata[4:0] = s.range;
               next_s.prdata[`PVC_STAT_LOCK_BIT] = s.lock;
               next_s.prdata[`PVC_STAT_DONE_BIT] = s.done_n;
               next_s.prdata[`PVC_STAT_BUSY_BIT] =
                  s.cal_st != pvc_pkg::CAL_IDLE;
            end
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         unique case (sel)
            `PVC_SEL_DIVN: begin
               next_s.cfg.a = pwdata[`PVC_DIVN_A_LSB +: 6];
               next_s.cfg.b = pwdata[`PVC_DIVN_B_LSB +: 9];
            end
            `PVC_SEL_REFDIV: next_s.r = pwdata[8:0];
            `PVC_SEL_CAL: begin
               next_s.cal_start = pwdata[`PVC_CAL_START_BIT];
               next_s.cal_rst = pwdata[`PVC_CAL_RST_BIT];
            end
            `PVC_SEL_CTRL: begin
               next_s.cp_sel = pwdata[`PVC_CTRL_CP_LSB +: 3];
               next_s.swing = {pwdata[`PVC_CTRL_SWHI_BIT],
                               pwdata[`PVC_CTRL_SWLO_BIT]};
               next_s.pd = pwdata[`PVC_CTRL_PD_BIT];
            end
            default: next_s.pd = s.pd;
         endcase
      end

      // reference divider, ratio reloaded only at its boundary
      if (ref_edge) begin
         if (s.ref_cnt + 9'h001 >= s.ref_sh) begin
            next_s.ref_pulse = 1'b1;
            next_s.ref_cnt = 9'h000;
            // zero would stall the comparator, so it acts as one
            next_s.ref_sh = (s.r == 9'h000) ? 9'h001 : s.r;
         end else begin
            next_s.ref_cnt = s.ref_cnt + 9'h001;
         end
      end

      // comparator: both high for one cycle, then each cleared unless its own pulse arrives that cycle
      if (s.up && s.dn) begin
         next_s.up = s.ref_pulse;
         next_s.dn = fb_pulse;
      end else begin
         next_s.up = s.up | s.ref_pulse;
         next_s.dn = s.dn | fb_pulse;
      end
      up_rise = next_s.up & ~s.up;
      dn_rise = next_s.dn & ~s.dn;

      // lock: gap between rising edges under the fixed window
      if (s.pd) begin
         next_s.lock = 1'b1;
         next_s.lk_run = 1'b0;
      end else if (up_rise && dn_rise) begin
         next_s.lock = 1'b1;
         next_s.lk_run = 1'b0;
      end else if (up_rise || dn_rise) begin
         if (s.lk_run) begin
            next_s.lock = ({1'b0, s.lk_gap} + 5'h01) <
                          5'(`PVC_LOCK_CYC);
            next_s.lk_run = 1'b0;
         end else begin
            next_s.lk_run = 1'b1;
            next_s.lk_gap = 4'h0;
         end
      end else if (s.lk_run && s.lk_gap != 4'hF) begin
         next_s.lk_gap = s.lk_gap + 4'h1;
      end

      // range search: settle period, five binary steps, finish
      if (s.cal_rst) begin
         next_s.cal_st = pvc_pkg::CAL_IDLE;
         next_s.range = `PVC_RANGE_MID;
         next_s.done_n = 1'b1;
      end else begin
         unique case (s.cal_st)
            pvc_pkg::CAL_IDLE: begin
               if (start_rise) begin
                  next_s.cal_st = pvc_pkg::CAL_SETTLE;
                  next_s.done_n = 1'b1;
               end
            end
            pvc_pkg::CAL_SETTLE: begin
               if (s.ref_pulse) begin
                  next_s.cal_st = pvc_pkg::CAL_STEP;
                  next_s.range = `PVC_RANGE_MID;
                  next_s.cal_bit = 3'h4;
                  next_s.fb_seen = 1'b0;
                  next_s.fb_restart = 1'b1;
               end
            end
            pvc_pkg::CAL_STEP: begin
               if (fb_pulse) begin
                  next_s.fb_seen = 1'b1;
               end
               if (s.ref_pulse) begin
                  // a feedback edge within one period means too fast
                  fast = s.fb_seen | fb_pulse;
                  if (fast) begin
                     next_s.range[s.cal_bit] = 1'b0;
                  end
                  next_s.fb_seen = 1'b0;
                  next_s.fb_restart = 1'b1;
                  if (s.cal_bit == 3'h0) begin
                     next_s.cal_st = pvc_pkg::CAL_FINISH;
                  end else begin
                     next_s.cal_bit = s.cal_bit - 3'h1;
                     next_s.range[s.cal_bit - 3'h1] = 1'b1;
                  end
               end
            end
            pvc_pkg::CAL_FINISH: begin
               if (s.ref_pulse) begin
                  next_s.cal_st = pvc_pkg::CAL_IDLE;
                  next_s.done_n = 1'b0;
               end
            end
         endcase
      end

      // pump off and tuning node at mid-supply while searching
      next_s.tune_mid = next_s.cal_st != pvc_pkg::CAL_IDLE;
      next_s.pump_up = next_s.up & ~next_s.tune_mid & ~next_s.pd;
      next_s.pump_dn = next_s.dn & ~next_s.tune_mid & ~next_s.pd;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.cfg.b <= `PVC_RST_B;
         s.cfg.a <= `PVC_RST_A;
         s.r <= `PVC_RST_R;
         s.ref_sh <= `PVC_RST_R;
         s.range <= `PVC_RANGE_MID;
         s.done_n <= 1'b1;
         s.cal_st <= pvc_pkg::CAL_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign pump_output_pin_up = s.pump_up;
   assign pump_output_pin_dn = s.pump_dn;
   // level scales the external resistor minimum current
   assign pump_level = s.cp_sel;
   assign tune_voltage_pin_mid = s.tune_mid;
   assign swing_select_lo = s.swing[0];
   assign swing_select_hi = s.swing[1];
   assign cal_range_word = s.range;
   assign cal_done_n = s.done_n;
   assign lock_det = s.lock;

   // helper count of comparison periods inside one search
   logic [3:0] h_per;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_per <= 4'h0;
      end else if (s.cal_st == pvc_pkg::CAL_IDLE) begin
         h_per <= 4'h0;
      end else if (s.ref_pulse) begin
         h_per <= h_per + 4'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pump_held_off: assert property (s.cal_st != pvc_pkg::CAL_IDLE
      |-> !pump_output_pin_up && !pump_output_pin_dn && tune_voltage_pin_mid)
      else $error("pump active during search");
   a_pd_lock_high: assert property (s.pd ##1 s.pd |-> lock_det)
      else $error("lock low in power-down");
   a_start_edge_only: assert property (s.cal_st == pvc_pkg::CAL_IDLE
      && !s.cal_rst && !(s.cal_start && !s.start_prev)
      |=> s.cal_st == pvc_pkg::CAL_IDLE)
      else $error("search began without a rising start bit");
   a_done_falls: assert property (s.cal_st == pvc_pkg::CAL_FINISH
      && s.ref_pulse && !s.cal_rst
      |=> !cal_done_n && s.cal_st == pvc_pkg::CAL_IDLE
      ##1 !tune_voltage_pin_mid)
      else $error("done flag or pump not restored");
   a_done_high_busy: assert property (s.cal_st != pvc_pkg::CAL_IDLE
      |-> cal_done_n)
      else $error("done flag low during search");
   a_cal_seven_per: assert property ($fell(cal_done_n)
      |-> h_per == `PVC_CAL_PERIODS)
      else $error("search length not seven periods");
   a_pfd_overlap: assert property (s.up && s.dn && !s.ref_pulse
      && !fb_pulse |=> !s.up && !s.dn)
      else $error("overlap pulse not one cycle");
   a_lock_coincide: assert property ($rose(s.up) && $rose(s.dn)
      && !s.pd |-> lock_det)
      else $error("coincident edges did not flag lock");

endmodule

/* verilog/pvc_consts.svh */
`ifndef PVC_CONSTS_SVH
`define PVC_CONSTS_SVH

// register byte offsets
`define PVC_ADDR_DIVN     12'h000
`define PVC_ADDR_REFDIV   12'h004
`define PVC_ADDR_CAL      12'h008
`define PVC_ADDR_CTRL     12'h00C
`define PVC_ADDR_STATUS   12'h010

// decode codes
`define PVC_SEL_NONE      3'h0
`define PVC_SEL_DIVN      3'h1
`define PVC_SEL_REFDIV    3'h2
`define PVC_SEL_CAL       3'h3
`define PVC_SEL_CTRL      3'h4
`define PVC_SEL_STATUS    3'h5

// field positions
`define PVC_DIVN_A_LSB    0
`define PVC_DIVN_B_LSB    8
`define PVC_CAL_START_BIT 0
`define PVC_CAL_RST_BIT   1
`define PVC_CTRL_CP_LSB   0
`define PVC_CTRL_SWLO_BIT 4
`define PVC_CTRL_SWHI_BIT 5
`define PVC_CTRL_PD_BIT   8
`define PVC_STAT_LOCK_BIT 8
`define PVC_STAT_DONE_BIT 9
`define PVC_STAT_BUSY_BIT 10

// reset values
`define PVC_RST_B         9'h040
`define PVC_RST_A         6'h00
`define PVC_RST_R         9'h001
`define PVC_RANGE_MID     5'h10

// prescaler: 4/5 core followed by a sixteen-stage count
`define PVC_CORE_LO       3'h3
`define PVC_CORE_HI       3'h4
`define PVC_STAGE_LAST    4'hF

// timing
`define PVC_CLK_MHZ       10
`define PVC_LOCK_NS       5
`define PVC_LOCK_RAW      (`PVC_LOCK_NS * `PVC_CLK_MHZ / 1000)
`define PVC_LOCK_CYC      ((`PVC_LOCK_RAW < 1) ? 1 : `PVC_LOCK_RAW)
`define PVC_CAL_PERIODS   4'h7

`endif

/* verilog/pvc_pkg.sv */
package pvc_pkg;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_SETTLE,
      CAL_STEP,
      CAL_FINISH
   } pvc_cal_e;

   typedef struct packed {
      logic [8:0] b;
      logic [5:0] a;
   } pvc_div_cfg_s;

   typedef struct packed {
      logic [2:0] core;
      logic [3:0] stage;
      logic [5:0] a_left;
      logic [8:0] b_left;
      logic       fb_pulse;
   } pvc_fb_s;

   typedef struct packed {
      pvc_div_cfg_s cfg;
      logic [8:0]   r;
      logic [2:0]   cp_sel;
      logic [1:0]   swing;
      logic         pd;
      logic         cal_start;
      logic         cal_rst;
      logic         start_prev;
      logic         ref_prev;
      logic         vco_prev;
      logic [8:0]   ref_cnt;
      logic [8:0]   ref_sh;
      logic         ref_pulse;
      logic         up;
      logic         dn;
      logic         pump_up;
      logic         pump_dn;
      logic         tune_mid;
      logic         lk_run;
      logic [3:0]   lk_gap;
      logic         lock;
      pvc_cal_e     cal_st;
      logic [2:0]   cal_bit;
      logic [4:0]   range;
      logic         done_n;
      logic         fb_seen;
      logic         fb_restart;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } pvc_top_s;

endpackage

/* verilog/pvc_fbdiv.sv */
`timescale 1ns/10ps
`include "pvc_consts.svh"

module pvc_fbdiv (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  vco_edge,
   input  wire logic                  restart,
   input  wire pvc_pkg::pvc_div_cfg_s cfg,
   output logic                       fb_pulse
);

   pvc_pkg::pvc_fb_s s;
   pvc_pkg::pvc_fb_s next_s;
   logic             use5;
   logic             core_end;
   logic             pre_pulse;

   assign fb_pulse = s.fb_pulse;

   always_comb begin
      next_s = s;
      next_s.fb_pulse = 1'b0;
      // modulus control comes from the swallow count
      use5 = (s.a_left != 6'h00) && (s.stage == 4'h0);
      core_end = vco_edge &&
                 (s.core == (use5 ? `PVC_CORE_HI : `PVC_CORE_LO));
      pre_pulse = core_end && (s.stage == `PVC_STAGE_LAST);
      if (restart) begin
         next_s.core = 3'h0;
         next_s.stage = 4'h0;
         next_s.a_left = cfg.a;
         next_s.b_left = cfg.b;
      end else if (vco_edge) begin
         if (core_end) begin
            next_s.core = 3'h0;
            next_s.stage = s.stage + 4'h1;
         end else begin
            next_s.core = s.core + 3'h1;
         end
         if (pre_pulse) begin
            // swallow count keeps the 65 modulus for a cycles
            if (s.a_left != 6'h00) begin
               next_s.a_left = s.a_left - 6'h01;
            end
            // total period is b*64 + a input edges while b exceeds a, up to 32767
            if (s.b_left <= 9'h001) begin
               next_s.fb_pulse = 1'b1;
               // new a and b only at the period boundary or on restart
               next_s.a_left = cfg.a;
               next_s.b_left = cfg.b;
            end else begin
               next_s.b_left = s.b_left - 9'h001;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // helper count of input edges per feedback period
   logic [15:0] h_cnt;
   logic [15:0] h_n;
   logic        h_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_cnt <= 16'h0000;
         h_n <= 16'h0000;
         h_ok <= 1'b0;
      end else if (restart) begin
         h_ok <= 1'b0;
         h_cnt <= 16'h0000;
      end else if (s.fb_pulse) begin
         h_cnt <= vco_edge ? 16'h0001 : 16'h0000;
         h_n <= {1'b0, s.b_left, 6'h00} + {10'h000, s.a_left};
         h_ok <= s.b_left > {3'h0, s.a_left};
      end else if (vco_edge) begin
         h_cnt <= h_cnt + 16'h0001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fb_total_ratio: assert property (h_ok && s.fb_pulse |->
      h_cnt == h_n)
      else $error("feedback period differs from b*64+a");
   a_swallow_load: assert property (s.fb_pulse |->
      s.a_left == $past(cfg.a))
      else $error("swallow count not loaded at boundary");
   a_core_modulus: assert property (s.core == `PVC_CORE_HI |->
      s.a_left != 6'h00 && s.stage == 4'h0)
      else $error("core divided by five outside swallow cycle");
   a_load_boundary: assert property ($changed(s.b_left) |->
      $past(pre_pulse || restart))
      else $error("main count changed inside a period");

endmodule

/* tb/pvc_vco_model.sv */
`timescale 1ns/10ps

module pvc_vco_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [4:0] range,
   output logic            ref_in,
   output logic            vco_in
);
   int vco_cnt;
   logic ref_ph;

   initial begin
      ref_in = 1'b0;
      vco_in = 1'b0;
      ref_ph = 1'b0;
      vco_cnt = 0;
   end

   // reference runs free from time zero, so it is live before a search
   always @(posedge pclk) begin
      ref_ph <= ~ref_ph;
      if (ref_ph) begin
         ref_in <= ~ref_in;
      end
   end

   // higher range word gives a shorter period; each level lasts >= 1 clock
   always @(posedge pclk) begin
      if (!presetn || vco_cnt >= (31 - int'(range)) / 8) begin
         vco_cnt <= 0;
         vco_in <= ~vco_in;
      end else begin
         vco_cnt <= vco_cnt + 1;
      end
   end
endmodule

/* tb/pvc_top_bench.sv */
`timescale 1ns/10ps

module pvc_top_bench;
   localparam int RDIV = 150;
   localparam int PER  = 4 * RDIV;
   localparam int NDIV = 129;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic        pready, pslverr, ref_in, vco_in, tune_voltage_pin_mid;
   logic        pump_output_pin_up, pump_output_pin_dn, lock_det;
   logic        swing_select_lo, swing_select_hi, cal_done_n;
   logic [2:0]  pump_level;
   logic [4:0]  cal_range_word;
   int          error_cnt, checked, cyc, t0, n;

   pvc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ref_in, .vco_in,
      .pump_output_pin_up, .pump_output_pin_dn, .pump_level,
      .tune_voltage_pin_mid, .swing_select_lo, .swing_select_hi,
      .cal_range_word, .cal_done_n, .lock_det);

   pvc_vco_model u_vco (.pclk, .presetn, .range(cal_range_word), .ref_in,
      .vco_in);

   always #50 pclk = ~pclk;

   task results();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         results();
      end
   end

   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         $display("wrong value %s expected %h seen %h", nm, ex, got);
         error_cnt++;
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // request held until the rising edge that sees pready; the run
      // timeout is the only limit on this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // search model: a bit is kept while the trial range is too slow
   function automatic logic [4:0] exp_range();
      logic [4:0] acc;
      logic [4:0] t;
      acc = 5'h00;
      for (int b = 4; b >= 0; b--) begin
         t = acc | (5'h01 << b);
         if (NDIV * 2 * (1 + (31 - int'(t)) / 8) > PER) acc = t;
      end
      return acc;
   endfunction

   task wait_tune();
      n = 0;
      while (tune_voltage_pin_mid !== 1'b1 && n < 6) begin
         @(negedge pclk);
         n++;
      end
   endtask

   always @(negedge pclk) begin
      if (presetn === 1'b1 && tune_voltage_pin_mid === 1'b1)
         chk("pump off in search", 3'h1, {pump_output_pin_up,
             pump_output_pin_dn, cal_done_n});
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      error_cnt = 0;
      checked = 0;
      cyc = 0;
      d = $urandom(22714);
      repeat (12) @(posedge pclk);
      chk("range at reset", 5'h10, cal_range_word);
      chk("done at reset", 1'b1, cal_done_n);
      presetn <= 1'b1;
      // main count kept above swallow count, ratio 4096..32767
      d = {15'h0000, 9'(64 + $urandom % 448), 2'h0, 6'($urandom % 64)};
      apb(1'b1, 12'h000, d);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("divider word", d, rd);
      apb(1'b1, 12'h004, RDIV);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("reference word", RDIV, rd);
      for (int i = 0; i < 8; i++) begin
         d = {26'h0, 2'($urandom % 4), 1'b0, 3'(i)};
         apb(1'b1, 12'h00C, d);
         // write lands on the access edge; look once it has settled
         @(negedge pclk);
         chk("pump level", i, pump_level);
         chk("swing", d[5:4], {swing_select_hi, swing_select_lo});
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk("control word", d, rd);
      end
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk("unmapped data", 32'h0000_0000, rd);
      chk("unmapped error", 1'b1, err);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      chk("status write error", 1'b1, err);
      apb(1'b1, 12'h00C, 32'h0000_0100);
      repeat (2) @(negedge pclk);
      chk("power down", 3'h4,
          {lock_det, pump_output_pin_up, pump_output_pin_dn});
      apb(1'b1, 12'h00C, 32'h0000_0003);
      apb(1'b1, 12'h000, 32'h0000_0201);
      // search runs at a comparison period of 60 us, under 1 MHz
      apb(1'b1, 12'h008, 32'h0000_0001);
      t0 = cyc;
      wait_tune();
      chk("search started", 1'b1, tune_voltage_pin_mid);
      n = 0;
      while (cal_done_n !== 1'b0 && n < 10 * PER) begin
         @(negedge pclk);
         n++;
      end
      chk("search length", 1'b1,
          (cyc - t0 >= 6 * PER) && (cyc - t0 <= 8 * PER));
      chk("tune released", 1'b0, tune_voltage_pin_mid);
      chk("chosen range", exp_range(), cal_range_word);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("status", {exp_range(), 3'h0}, {rd[4:0], rd[10:8]});
      repeat (3 * PER) @(posedge pclk);
      chk("no search on steady bit", 1'b0, cal_done_n);
      apb(1'b1, 12'h008, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0001);
      wait_tune();
      chk("second search", 2'h3,
          {tune_voltage_pin_mid, cal_done_n});
      repeat (2 * PER) @(posedge pclk);
      apb(1'b1, 12'h008, 32'h0000_0002);
      repeat (2) @(negedge pclk);
      chk("search reset", 7'h42,
          {cal_range_word, cal_done_n, tune_voltage_pin_mid});
      apb(1'b1, 12'h008, 32'h0000_0000);
      results();
   end
endmodule
